// file: design/rtc_irq_pkg.sv
// Contract
// R1 - three sources, each with own enable bit
// R2 - interrupt is flag AND enable, ORed
// R3 - pulse mode drives pin about 200 ms
// R4 - level mode holds pin until flags read
// R5 - no interrupts while on backup supply
// R6 - pin valid only after restore completes
// R7 - host ignores pin during first access delay
// R8 - watchdog enable gates pin; flag always set
// R9 - alarm enable gates pin; flag always set
// R10 - power-fail enable gates pin; flag always set
// R11 - square wave overrides interrupts; calibration wins
// R12 - wave enable and select are nonvolatile
// R13 - select codes give 1/512/4096/32768 Hz
// R14 - polarity bit picks push-pull high or open-drain low
// R15 - flags read clears all flags at once
// R16 - flags read truncates a running pulse
// R17 - host does not read flags during reset
// R18 - fixed pin priority: cal, wave, irq, off
// R19 - flags set regardless of enables
// R20 - flags load zero at power-up
// R21 - event during clearing read keeps its flag
package rtc_irq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int PULSE_TIME_MS = 200;
  localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_TIME_MS;
  localparam int OSC_HZ = 32768;
  // half period of the oscillator, rounded down
  localparam int BASE_DIV_CYCLES = CLK_HZ / (2 * OSC_HZ);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_CONTROL = 4'h6;
  localparam logic [DATA_W-1:0] EVENT_FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] INTERRUPT_CONTROL_RESET = 8'h08;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // event_flags fields
  localparam int FLAG_WDOG = 7;
  localparam int FLAG_ALARM = 6;
  localparam int FLAG_PWRFAIL = 5;
  localparam int FLAG_OSCFAIL = 4;
  localparam int FLAG_BKPFAIL = 3;
  localparam int FLAG_CAL = 2;
  localparam int FLAG_WRITE = 1;
  localparam int FLAG_READ = 0;

  // interrupt_control fields
  localparam int CTRL_WDOG_EN = 7;
  localparam int CTRL_ALARM_EN = 6;
  localparam int CTRL_PWRFAIL_EN = 5;
  localparam int CTRL_SQW_EN = 4;
  localparam int CTRL_HIGH = 3;
  localparam int CTRL_PULSE = 2;
  localparam int CTRL_SEL_HI = 1;
  localparam int CTRL_SEL_LO = 0;

  // ----------------------------------------------------------------
  // square wave taps of the 65536 Hz phase counter
  // ----------------------------------------------------------------
  localparam int PHASE_W = 16;
  localparam int TAP_1HZ = 15;
  localparam int TAP_512HZ = 6;
  localparam int TAP_4096HZ = 3;
  localparam int TAP_32768HZ = 0;

  typedef enum logic [1:0] {SQW_1HZ, SQW_512HZ, SQW_4096HZ, SQW_32768HZ} sqw_freq_t;
  typedef enum logic [1:0] {PIN_OFF, PIN_CAL, PIN_SQW, PIN_IRQ} pin_src_t;

  // returns {pin level, output enable}
  function automatic logic [1:0] pin_drive(input logic active_high, input logic active);
    return active_high ? {active, 1'b1} : {1'b0, active};
  endfunction : pin_drive

endpackage : rtc_irq_pkg

// file: design/rtc_sqw_gen.sv
`timescale 1ns/10ps
module rtc_sqw_gen
  import rtc_irq_pkg::*;
#(
  parameter int BASE_DIV = BASE_DIV_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic run_in,
  input wire logic [1:0] freq_sel_in,
  // waves
  output logic wave_out,
  output logic tone_out
);

  localparam int DIV_W = $clog2(BASE_DIV + 1);

  if (BASE_DIV < 1) begin : g_bad_div
    $error("BASE_DIV must be at least 1");
  end

  logic [DIV_W-1:0] div_cnt;
  logic [PHASE_W-1:0] phase;
  logic base_tick;

  assign base_tick = (div_cnt == DIV_W'(BASE_DIV - 1));

  // ----------------------------------------------------------------
  // 65536 Hz tick and phase counter; held cleared while not running
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in || !run_in) begin
      div_cnt <= '0;
    end else if (base_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || !run_in) begin
      phase <= '0;
    end else if (base_tick) begin
      phase <= phase + PHASE_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wave_out <= 1'b0;
      tone_out <= 1'b0;
    end else begin
      tone_out <= phase[TAP_512HZ];
      unique case (sqw_freq_t'(freq_sel_in)) // [R13]
        SQW_1HZ: wave_out <= phase[TAP_1HZ];
        SQW_512HZ: wave_out <= phase[TAP_512HZ];
        SQW_4096HZ: wave_out <= phase[TAP_4096HZ];
        SQW_32768HZ: wave_out <= phase[TAP_32768HZ];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SQW_TAP_FAST: assert property (@(posedge clk_in) disable iff (reset_in) // [R13]
    (freq_sel_in == 2'h3) |=> (wave_out == $past(phase[TAP_32768HZ])))
    else $error("fastest select does not follow phase bit zero");

  AST_TONE_512: assert property (@(posedge clk_in) disable iff (reset_in) // [R18]
    1'b1 |=> (tone_out == $past(phase[TAP_512HZ])))
    else $error("calibration tone does not follow the 512 Hz tap");

endmodule : rtc_sqw_gen

// file: design/rtc_irq_top.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module rtc_irq_top
  import rtc_irq_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES,
  parameter int SQW_DIV = BASE_DIV_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [DATA_W-1:0] rd_data_out,
  // event sources, one-cycle pulses
  input wire logic wdog_timeout_in,
  input wire logic alarm_match_in,
  input wire logic power_fail_in,
  // supply and status levels
  input wire logic on_vcc_in,
  input wire logic recall_done_in,
  input wire logic osc_fail_in,
  input wire logic backup_fail_in,
  // nonvolatile copy of {square_wave_en, sqw_freq_sel_hi, sqw_freq_sel_lo}
  input wire logic [2:0] nv_sqw_cfg_in,
  output logic [2:0] nv_sqw_cfg_out,
  // interrupt pin
  output logic int_pin_out,
  output logic int_pin_oe_out
);

  localparam int PULSE_W = $clog2(PULSE_LEN + 1);

  if (PULSE_LEN < 1 || PULSE_LEN > 2**30) begin : g_bad_pulse
    $error("PULSE_LEN out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0] src_flags;
  logic cal_mode;
  logic flag_write_en;
  logic flag_read_bit;
  logic [DATA_W-1:0] ctrl;
  logic recall_seen;
  logic [PULSE_W-1:0] pulse_cnt;
  pin_src_t pin_src;
  logic [DATA_W-1:0] flags_view;
  logic [2:0] src_events;
  logic [2:0] src_enables;
  logic irq_gate;
  logic flags_read;
  logic flags_write;
  logic ctrl_write;
  logic irq_level;
  logic pulse_start;
  logic pulse_active;
  logic irq_active;
  logic sqw_wave;
  logic cal_tone;
  logic [1:0] next_drive;
  pin_src_t next_pin_src;

  assign src_events = {wdog_timeout_in, alarm_match_in, power_fail_in};
  assign src_enables = ctrl[CTRL_WDOG_EN:CTRL_PWRFAIL_EN]; // [R1]
  assign irq_gate = on_vcc_in && recall_done_in; // [R5] [R6]
  assign flags_read = rd_en_in && (addr_in == ADDR_EVENT_FLAGS);
  assign flags_write = wr_en_in && (addr_in == ADDR_EVENT_FLAGS);
  assign ctrl_write = wr_en_in && (addr_in == ADDR_INTERRUPT_CONTROL);

  assign flags_view = {src_flags, osc_fail_in, backup_fail_in, cal_mode, flag_write_en, flag_read_bit};

  // ----------------------------------------------------------------
  // source flags: set by event, cleared by read, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      src_flags <= EVENT_FLAGS_RESET[FLAG_WDOG:FLAG_PWRFAIL]; // [R20]
    end else begin
      // [R19] [R15] [R21]
      src_flags <= src_events | (src_flags & ~{3{flags_read}});
    end
  end

  // ----------------------------------------------------------------
  // writable flag bits; calibration only while write bit is set
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cal_mode <= EVENT_FLAGS_RESET[FLAG_CAL];
      flag_write_en <= EVENT_FLAGS_RESET[FLAG_WRITE];
      flag_read_bit <= EVENT_FLAGS_RESET[FLAG_READ];
    end else if (flags_write) begin
      flag_write_en <= wr_data_in[FLAG_WRITE];
      flag_read_bit <= wr_data_in[FLAG_READ];
      if (flag_write_en) begin
        cal_mode <= wr_data_in[FLAG_CAL];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt control; wave bits reloaded once the restore completes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      recall_seen <= 1'b0;
    end else begin
      recall_seen <= recall_done_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl <= INTERRUPT_CONTROL_RESET; // [R12]
    end else if (recall_done_in && !recall_seen) begin
      ctrl[CTRL_SQW_EN] <= nv_sqw_cfg_in[2]; // [R12]
      ctrl[CTRL_SEL_HI] <= nv_sqw_cfg_in[1];
      ctrl[CTRL_SEL_LO] <= nv_sqw_cfg_in[0];
    end else if (ctrl_write) begin
      ctrl <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      nv_sqw_cfg_out <= {INTERRUPT_CONTROL_RESET[CTRL_SQW_EN], INTERRUPT_CONTROL_RESET[CTRL_SEL_HI:CTRL_SEL_LO]};
    end else begin
      nv_sqw_cfg_out <= {ctrl[CTRL_SQW_EN], ctrl[CTRL_SEL_HI:CTRL_SEL_LO]}; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // read port: data stands one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_data_out <= UNMAPPED_READ;
    end else if (rd_en_in) begin
      unique case (addr_in)
        ADDR_EVENT_FLAGS: rd_data_out <= flags_view;
        ADDR_INTERRUPT_CONTROL: rd_data_out <= ctrl;
        default: rd_data_out <= UNMAPPED_READ;
      endcase
    end else begin
      rd_data_out <= UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request: per-source AND, then OR
  // ----------------------------------------------------------------
  // [R2] [R8] [R9] [R10]
  assign irq_level = irq_gate && |(src_flags & src_enables);
  // a new enabled event while on normal power and after the restore starts a pulse
  assign pulse_start = irq_gate && |(src_events & src_enables);
  assign pulse_active = (pulse_cnt != '0);
  // [R3] [R4]
  assign irq_active = ctrl[CTRL_PULSE] ? pulse_active : irq_level;

  // ----------------------------------------------------------------
  // pulse timer; a flags read ends it unless a new enabled event arrives
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pulse_cnt <= '0;
    end else if (!irq_gate) begin
      pulse_cnt <= '0; // [R5]
    end else if (pulse_start) begin
      pulse_cnt <= PULSE_W'(PULSE_LEN); // [R3]
    end else if (flags_read) begin
      pulse_cnt <= '0; // [R16]
    end else if (pulse_active) begin
      pulse_cnt <= pulse_cnt - PULSE_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // square wave and calibration tone
  // ----------------------------------------------------------------
  rtc_sqw_gen #(
    .BASE_DIV(SQW_DIV)
  ) u_sqw (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(irq_gate),
    .freq_sel_in(ctrl[CTRL_SEL_HI:CTRL_SEL_LO]),
    .wave_out(sqw_wave),
    .tone_out(cal_tone)
  );

  // ----------------------------------------------------------------
  // pin source priority and driver
  // ----------------------------------------------------------------
  always_comb begin
    if (!irq_gate) begin
      next_pin_src = PIN_OFF; // [R5] [R6]
    end else if (cal_mode) begin
      next_pin_src = PIN_CAL; // [R18]
    end else if (ctrl[CTRL_SQW_EN]) begin
      next_pin_src = PIN_SQW; // [R11]
    end else if (|src_enables) begin
      next_pin_src = PIN_IRQ;
    end else begin
      next_pin_src = PIN_OFF;
    end
  end

  always_comb begin
    unique case (next_pin_src)
      PIN_CAL: next_drive = pin_drive(ctrl[CTRL_HIGH], cal_tone); // [R14]
      PIN_SQW: next_drive = pin_drive(ctrl[CTRL_HIGH], sqw_wave);
      PIN_IRQ: next_drive = pin_drive(ctrl[CTRL_HIGH], irq_active);
      PIN_OFF: next_drive = 2'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_src <= PIN_OFF;
      int_pin_out <= 1'b0;
      int_pin_oe_out <= 1'b0;
    end else begin
      pin_src <= next_pin_src;
      int_pin_out <= next_drive[1];
      int_pin_oe_out <= next_drive[0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_FLAG_ON_EVENT: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    src_events[1] |=> src_flags[1])
    else $error("alarm event did not set its flag");

  AST_READ_CLEARS: assert property (@(posedge clk_in) disable iff (reset_in) // [R15]
    (flags_read && src_events == 3'h0) |=> (src_flags == 3'h0))
    else $error("flags read did not clear all flags");

  AST_SET_WINS: assert property (@(posedge clk_in) disable iff (reset_in) // [R21]
    (flags_read && wdog_timeout_in) |=> src_flags[2] ##1 (rd_data_out[FLAG_WDOG] || !$past(flags_read)))
    else $error("event lost during clearing read");

  AST_READ_DATA: assert property (@(posedge clk_in) disable iff (reset_in) // [R1]
    (rd_en_in && addr_in == ADDR_INTERRUPT_CONTROL && !ctrl_write) |=> (rd_data_out == $past(ctrl)))
    else $error("control readback wrong");

  AST_BACKUP_QUIET: assert property (@(posedge clk_in) disable iff (reset_in) // [R5]
    !on_vcc_in |=> (!int_pin_oe_out && !int_pin_out && pin_src == PIN_OFF))
    else $error("pin active on backup supply");

  AST_RESTORE_QUIET: assert property (@(posedge clk_in) disable iff (reset_in) // [R6]
    !recall_done_in |=> !int_pin_oe_out)
    else $error("pin driven before restore completed");

  AST_LEVEL_HOLD: assert property (@(posedge clk_in) disable iff (reset_in) // [R4]
    (irq_gate && !cal_mode && !ctrl[CTRL_SQW_EN] && !ctrl[CTRL_PULSE] && ctrl[CTRL_HIGH] && irq_level)
    |=> (int_pin_out && int_pin_oe_out))
    else $error("level interrupt not driven");

  AST_NO_ENABLED_SOURCE: assert property (@(posedge clk_in) disable iff (reset_in) // [R2] [R8]
    (!cal_mode && !ctrl[CTRL_SQW_EN] && (src_flags & src_enables) == 3'h0 && !pulse_active)
    |=> !int_pin_out)
    else $error("pin active without an enabled flag");

  AST_PULSE_LOAD: assert property (@(posedge clk_in) disable iff (reset_in) // [R3]
    pulse_start |=> (pulse_cnt == PULSE_W'(PULSE_LEN)) ##1 (pulse_cnt != '0 || $past(flags_read) || !$past(irq_gate)))
    else $error("pulse length not loaded");

  AST_PULSE_TRUNC: assert property (@(posedge clk_in) disable iff (reset_in) // [R16]
    (flags_read && !pulse_start) |=> (pulse_cnt == '0))
    else $error("flags read did not end pulse");

  AST_CAL_FIRST: assert property (@(posedge clk_in) disable iff (reset_in) // [R18] [R11]
    (irq_gate && cal_mode) |=> (pin_src == PIN_CAL))
    else $error("calibration tone not given priority");

  AST_OPEN_DRAIN_LOW: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
    !ctrl[CTRL_HIGH] |=> !int_pin_out)
    else $error("open-drain mode drove the pin high");

  AST_WDOG_FLAG: assert property (@(posedge clk_in) disable iff (reset_in) // [R8]
    wdog_timeout_in |=> src_flags[2])
    else $error("watchdog event did not set its flag");

  AST_PWRFAIL_FLAG: assert property (@(posedge clk_in) disable iff (reset_in) // [R10]
    power_fail_in |=> src_flags[0])
    else $error("power-fail event did not set its flag");

  AST_FLAG_HOLD: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    !flags_read |=> ((src_flags & $past(src_flags)) == $past(src_flags)))
    else $error("flag dropped without a flags read");

  AST_FLAG_READBACK: assert property (@(posedge clk_in) disable iff (reset_in) // [R15]
    flags_read |=> (rd_data_out == $past(flags_view)))
    else $error("flags readback wrong");

  AST_NV_COPY: assert property (@(posedge clk_in) disable iff (reset_in) // [R12]
    1'b1 |=> (nv_sqw_cfg_out == {$past(ctrl[CTRL_SQW_EN]), $past(ctrl[CTRL_SEL_HI:CTRL_SEL_LO])}))
    else $error("nonvolatile copy does not follow control");

  AST_NV_RELOAD: assert property (@(posedge clk_in) disable iff (reset_in) // [R12]
    (recall_done_in && !recall_seen)
    |=> ({ctrl[CTRL_SQW_EN], ctrl[CTRL_SEL_HI:CTRL_SEL_LO]} == $past(nv_sqw_cfg_in)))
    else $error("wave settings not restored");

  AST_WAVE_PICK: assert property (@(posedge clk_in) disable iff (reset_in) // [R11]
    (irq_gate && !cal_mode && ctrl[CTRL_SQW_EN]) |=> (pin_src == PIN_SQW))
    else $error("square wave not given priority over interrupts");

  AST_PUSH_PULL: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
    (ctrl[CTRL_HIGH] && next_pin_src != PIN_OFF) |=> int_pin_oe_out)
    else $error("push-pull mode left the pin undriven");

  AST_PULSE_GATE: assert property (@(posedge clk_in) disable iff (reset_in) // [R5]
    !irq_gate |=> (pulse_cnt == '0))
    else $error("pulse kept running on backup supply");

  AST_HIZ_IDLE: assert property (@(posedge clk_in) disable iff (reset_in) // [R18]
    (irq_gate && !cal_mode && !ctrl[CTRL_SQW_EN] && src_enables == 3'h0)
    |=> (!int_pin_oe_out && !int_pin_out))
    else $error("pin driven with no source enabled");

  AST_PULSE_DRIVE: assert property (@(posedge clk_in) disable iff (reset_in) // [R3]
    (irq_gate && !cal_mode && !ctrl[CTRL_SQW_EN] && ctrl[CTRL_PULSE] && ctrl[CTRL_HIGH]
      && pulse_active && src_enables != 3'h0) |=> int_pin_out)
    else $error("running pulse not driven on the pin");

  COV_PULSE: cover property (@(posedge clk_in) disable iff (reset_in)
    pulse_start ##1 pulse_active [*3]);

  COV_LEVEL_READ: cover property (@(posedge clk_in) disable iff (reset_in)
    (pin_src == PIN_IRQ && int_pin_oe_out) ##[1:20] flags_read);

  COV_SQW: cover property (@(posedge clk_in) disable iff (reset_in)
    pin_src == PIN_SQW && int_pin_out);

  COV_CAL: cover property (@(posedge clk_in) disable iff (reset_in)
    pin_src == PIN_CAL);

  COV_TRUNC: cover property (@(posedge clk_in) disable iff (reset_in)
    pulse_active && flags_read);

endmodule : rtc_irq_top

// file: dv/rtc_irq_host.sv
`timescale 1ns/10ps
module rtc_irq_host
  import rtc_irq_pkg::*;
#(
  parameter int FIRST_ACCESS = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic wr_en_out,
  output logic rd_en_out,
  input wire logic [DATA_W-1:0] rd_data_in,
  // interrupt pin
  input wire logic int_pin_in,
  input wire logic int_pin_oe_in,
  output logic pin_level_out
);
  // ----------------------------------------------------------------
  // pin as the host sees it
  // ----------------------------------------------------------------
  int age = 0;

  always @(posedge clk_in) begin
    if (age < FIRST_ACCESS) begin
      age <= age + 1;
    end
  end

  // pin ignored right after power-up; undriven wire sits at the pull-up
  assign pin_level_out = (age < FIRST_ACCESS) ? 1'b1 : (int_pin_oe_in ? int_pin_in : 1'b1);

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  initial begin
    addr_out = 4'h0;
    wr_data_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    // no flags read while reset_in holds the host in reset
    while (reset_in) @(posedge clk_in);
    @(posedge clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rd_data_in;
  endtask : read_reg

endmodule : rtc_irq_host

// file: dv/test_rtc_irq_top.sv
`timescale 1ns/10ps
module test_rtc_irq_top;
  import rtc_irq_pkg::*;
  localparam int PL = 20;
  localparam logic [3:0] FL = ADDR_EVENT_FLAGS;
  localparam logic [3:0] CT = ADDR_INTERRUPT_CONTROL;

  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] ev = 3'h0; // bit 0 wdog, bit 1 alarm, bit 2 power fail
  logic on_vcc = 1'b1, recall_done = 1'b1, osc_fail = 1'b0, backup_fail = 1'b0;
  logic [2:0] nv_cfg_in = 3'h0;
  logic [2:0] nv_cfg_out;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic wr_en, rd_en, int_pin, int_pin_oe, pin_level;
  int bad_count = 0;
  int n_tests = 0;

  always #10 clk_in = ~clk_in;

  rtc_irq_top #(.PULSE_LEN(PL), .SQW_DIV(2)) i_dut (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wr_data_in(wr_data),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
    .wdog_timeout_in(ev[0]), .alarm_match_in(ev[1]), .power_fail_in(ev[2]),
    .on_vcc_in(on_vcc), .recall_done_in(recall_done), .osc_fail_in(osc_fail),
    .backup_fail_in(backup_fail), .nv_sqw_cfg_in(nv_cfg_in), .nv_sqw_cfg_out(nv_cfg_out),
    .int_pin_out(int_pin), .int_pin_oe_out(int_pin_oe)
  );

  rtc_irq_host i_host (
    .clk_in(clk_in), .reset_in(reset_in), .addr_out(addr), .wr_data_out(wr_data),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .rd_data_in(rd_data),
    .int_pin_in(int_pin), .int_pin_oe_in(int_pin_oe), .pin_level_out(pin_level)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    i_host.read_reg(a, d);
    check(d, exp);
    @(posedge clk_in);
    #1;
  endtask : rd_check

  // one-cycle event, returns when its effect reaches the pin
  task automatic fire(input int i);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev[i] <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask : fire

  // cycles until the pin level changes
  task automatic run_len(output int h);
    logic p;
    p = int_pin;
    h = 0;
    while (int_pin === p && h < 1000) begin
      @(posedge clk_in);
      #1;
      h++;
    end
    if (h >= 1000) begin
      bad_count++;
      complete_run();
    end
  endtask : run_len

  task automatic half(output int h);
    run_len(h);
    run_len(h);
  endtask : half

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(posedge clk_in);
    osc_fail <= 1'b1;
    backup_fail <= 1'b1;
    rd_check(CT, INTERRUPT_CONTROL_RESET);
    rd_check(FL, 8'h18);
    i_host.write_reg(4'h3, 8'hFF);
    rd_check(4'h3, UNMAPPED_READ);
    rd_check(CT, 8'h08);
    @(posedge clk_in);
    osc_fail <= 1'b0;
    backup_fail <= 1'b0;
    $display("reset values done");
  endtask : t_reset

  task automatic t_sources();
    for (int i = 0; i < 3; i++) begin
      i_host.write_reg(CT, 8'h08 | (8'h80 >> i));
      fire((i + 1) % 3);
      check({int_pin_oe, int_pin}, 2'b10);
      fire(i);
      check({int_pin_oe, int_pin}, 2'b11);
      rd_check(FL, (8'h80 >> i) | (8'h80 >> ((i + 1) % 3)));
      check({int_pin_oe, int_pin}, 2'b10);
    end
    $display("sources done");
  endtask : t_sources

  task automatic t_pulse();
    int n;
    i_host.write_reg(CT, 8'h4C);
    fire(1);
    run_len(n);
    check(n >= PL && n <= PL + 2, 1'b1);
    rd_check(FL, 8'h40);
    fire(1);
    repeat (3) @(posedge clk_in);
    rd_check(FL, 8'h40);
    check({int_pin_oe, int_pin}, 2'b10);
    $display("pulse done");
  endtask : t_pulse

  task automatic t_open_drain();
    i_host.write_reg(CT, 8'h40);
    repeat (2) @(posedge clk_in);
    #1;
    check({int_pin_oe, pin_level}, 2'b01);
    fire(1);
    check({int_pin_oe, int_pin, pin_level}, 3'b100);
    rd_check(FL, 8'h40);
    check({int_pin_oe, pin_level}, 2'b01);
    $display("open drain done");
  endtask : t_open_drain

  task automatic t_wave();
    int h[4];
    int c;
    for (int s = 3; s > 0; s--) begin
      i_host.write_reg(CT, 8'h58 | 8'(s));
      fire(1);
      half(h[s]);
    end
    check(h[2], 8 * h[3]);
    check(h[1], 64 * h[3]);
    i_host.write_reg(CT, 8'h18);
    repeat (3) @(posedge clk_in);
    #1;
    check(int_pin_oe, 1'b1);
    // slowest select: no high level within a span where 512 Hz would toggle
    c = 0;
    repeat (300) begin
      @(posedge clk_in);
      #1;
      c += int_pin;
    end
    check(c, 0);
    i_host.write_reg(FL, 8'h02);
    i_host.write_reg(FL, 8'h06);
    repeat (3) @(posedge clk_in);
    #1;
    half(c);
    check(c, h[1]);
    i_host.write_reg(FL, 8'h02);
    i_host.write_reg(FL, 8'h00);
    i_host.write_reg(CT, 8'h08);
    repeat (2) @(posedge clk_in);
    #1;
    check(int_pin_oe, 1'b0);
    rd_check(FL, 8'h40);
    $display("square wave done");
  endtask : t_wave

  task automatic t_coincide();
    fork
      rd_check(FL, 8'h00);
      begin
        @(posedge clk_in);
        ev[0] <= 1'b1;
        @(posedge clk_in);
        ev[0] <= 1'b0;
      end
    join
    rd_check(FL, 8'h80);
    $display("coincident event done");
  endtask : t_coincide

  task automatic t_gate();
    i_host.write_reg(CT, 8'h48);
    @(posedge clk_in);
    on_vcc <= 1'b0;
    fire(1);
    check(int_pin_oe, 1'b0);
    @(posedge clk_in);
    on_vcc <= 1'b1;
    recall_done <= 1'b0;
    nv_cfg_in <= 3'b101;
    fire(1);
    check(int_pin_oe, 1'b0);
    rd_check(FL, 8'h40);
    @(posedge clk_in);
    recall_done <= 1'b1;
    rd_check(CT, 8'h59);
    check(nv_cfg_out, 3'b101);
    $display("supply gate done");
  endtask : t_gate

  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    t_reset();
    t_sources();
    t_pulse();
    t_open_drain();
    t_wave();
    t_coincide();
    t_gate();
    complete_run();
  end

endmodule : test_rtc_irq_top
